// >>> iafpc_flash_ctrl.v
// In-application flash program controller with Wishbone mailbox registers
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "iafpc_regs.vh"
module iafpc_flash_ctrl #(
	parameter [7:0] MAKER_SIG = 8'h5a,
	parameter [7:0] DEVICE_SIG = 8'ha5,
	parameter ERASE_CYCLES = `IAFPC_ERASE_CYC
) (
	input wire ref_clk_in,
	input wire rst_b_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [7:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	input wire external_access_pin_in,
	input wire [15:0] fetch_addr_in,
	input wire fetch_external_in,
	output wire main_fetch_busy_out,
	output wire second_fetch_busy_out,
	output reg flash_we_out,
	output reg flash_sector_erase_out,
	output reg flash_target_second_out,
	output reg [15:0] flash_addr_out,
	output reg [7:0] flash_wdata_out,
	input wire [7:0] flash_rdata_in,
	output reg osc_enable_out,
	output reg completion_interrupt_source_out
);
	// ***************
	// Block choice: 2 = second block, 1 = main block, 0 = no block
	// ***************
	localparam [1:0] TGT_NONE = 2'h0;
	localparam [1:0] TGT_MAIN = 2'h1;
	localparam [1:0] TGT_SECOND = 2'h2;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RUN = 2'h1;
	localparam [1:0] ST_DONE = 2'h2;

	reg [7:0] flash_status_reg;
	reg [7:0] flash_command_reg;
	reg [7:0] flash_addr_low_reg;
	reg [7:0] flash_addr_high_reg;
	reg [7:0] flash_data_reg;
	reg [7:0] flash_config_reg;
	reg [1:0] lock_reg;
	reg [1:0] state;
	reg [31:0] count;
	reg refused;
	// Verify reads the array one cycle after the address is presented
	reg verify_wait;

	// Which physical block holds a 16-bit fetch address under current overlay
	function fetch_in_second;
		input [15:0] a;
		input pin;
		input [1:0] bank;
		begin
			fetch_in_second = pin && (bank == 2'h0) && (a < `IAFPC_OVERLAY_LIMIT);
		end
	endfunction

	// Target resolution; the issuing block is never the target while the access pin is high
	function [1:0] resolve;
		input [15:0] src;
		input ext;
		input [15:0] tgt;
		input pin;
		input [1:0] bank;
		reg src_second;
		reg low;
		begin
			src_second = fetch_in_second(src, pin, bank);
			low = tgt < `IAFPC_OVERLAY_LIMIT;
			if (ext || !pin) begin
				resolve = (bank == 2'h0 && low) ? TGT_SECOND : TGT_MAIN;
			end else if (src_second) begin
				resolve = TGT_MAIN;
			end else if (low) begin
				resolve = TGT_SECOND;
			end else begin
				resolve = TGT_NONE;
			end
		end
	endfunction

	wire [15:0] tgt_addr = {flash_addr_high_reg, flash_addr_low_reg};
	wire [1:0] tgt_block = resolve(fetch_addr_in, fetch_external_in, tgt_addr,
		external_access_pin_in, flash_config_reg[1:0]);
	wire iap_on = flash_config_reg[`IAFPC_CFG_ENABLE_BIT];
	wire busy = (state == ST_RUN);
	wire wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	wire wr_cmd = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == `IAFPC_OFS_COMMAND);
	wire [6:0] op = wb_dat_in[6:0];
	wire is_long = (op == `IAFPC_CMD_BYTE_PROGRAM) || (op == `IAFPC_CMD_SECTOR_ERASE);
	wire tgt_locked = (tgt_block == TGT_MAIN) ? lock_reg[0] : lock_reg[1];
	// Busy flags let the fetch side stall only the block being changed
	assign main_fetch_busy_out = busy && !flash_target_second_out;
	assign second_fetch_busy_out = busy && flash_target_second_out;

	// ***************
	// Wishbone slave, ack registered one cycle after the request
	// ***************
	reg [7:0] rd_byte;
	always @* begin
		case (wb_adr_in)
		`IAFPC_OFS_STATUS: rd_byte = flash_status_reg;
		`IAFPC_OFS_COMMAND: rd_byte = flash_command_reg;
		`IAFPC_OFS_ADDR_LOW: rd_byte = flash_addr_low_reg;
		`IAFPC_OFS_ADDR_HIGH: rd_byte = flash_addr_high_reg;
		`IAFPC_OFS_DATA: rd_byte = flash_data_reg;
		`IAFPC_OFS_CONFIG: rd_byte = flash_config_reg;
		`IAFPC_OFS_LOCK: rd_byte = {6'h00, lock_reg};
		default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_req;
			wb_dat_out <= wb_req ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// ***************
	// Mailbox registers and sequencer
	// ***************
	always @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			flash_command_reg <= `IAFPC_RST_BYTE;
			flash_addr_low_reg <= `IAFPC_RST_BYTE;
			flash_addr_high_reg <= `IAFPC_RST_BYTE;
			flash_data_reg <= `IAFPC_RST_BYTE;
			flash_config_reg <= `IAFPC_RST_BYTE;
			lock_reg <= 2'h0;
			state <= ST_IDLE;
			count <= 32'h00000000;
			refused <= 1'b0;
			verify_wait <= 1'b0;
			flash_we_out <= 1'b0;
			flash_sector_erase_out <= 1'b0;
			flash_target_second_out <= 1'b0;
			flash_addr_out <= 16'h0000;
			flash_wdata_out <= 8'h00;
			osc_enable_out <= 1'b0;
			completion_interrupt_source_out <= 1'b0;
		end else begin
			flash_we_out <= 1'b0;
			flash_sector_erase_out <= 1'b0;
			completion_interrupt_source_out <= 1'b0;
			if (wb_req && wb_we_in && wb_sel_in[0] && !busy) begin
				case (wb_adr_in)
				`IAFPC_OFS_ADDR_LOW: flash_addr_low_reg <= wb_dat_in[7:0];
				`IAFPC_OFS_ADDR_HIGH: flash_addr_high_reg <= wb_dat_in[7:0];
				`IAFPC_OFS_DATA: flash_data_reg <= wb_dat_in[7:0];
				`IAFPC_OFS_CONFIG: flash_config_reg <= wb_dat_in[7:0];
				`IAFPC_OFS_LOCK: lock_reg <= lock_reg | wb_dat_in[1:0];
				default: ;
				endcase
			end
			if (verify_wait) begin
				flash_data_reg <= flash_rdata_in;
				verify_wait <= 1'b0;
			end
			case (state)
			ST_IDLE: begin
				if (wr_cmd) begin
					flash_command_reg <= wb_dat_in[7:0];
					refused <= 1'b0;
					if (!iap_on) begin
						refused <= 1'b1;
					end else if (op == `IAFPC_CMD_SIG_READ) begin
						flash_data_reg <= (flash_addr_low_reg == `IAFPC_SIG_MAKER_ADDR) ?
							MAKER_SIG : DEVICE_SIG;
					end else if (tgt_block == TGT_NONE || tgt_locked) begin
						refused <= 1'b1;
					end else if (op == `IAFPC_CMD_BYTE_VERIFY) begin
						flash_target_second_out <= (tgt_block == TGT_SECOND);
						flash_addr_out <= tgt_addr;
						verify_wait <= 1'b1;
					end else if (is_long) begin
						flash_target_second_out <= (tgt_block == TGT_SECOND);
						flash_addr_out <= (op == `IAFPC_CMD_SECTOR_ERASE) ?
							{tgt_addr[15:7], 7'h00} : tgt_addr;
						flash_wdata_out <= flash_data_reg;
						flash_we_out <= (op == `IAFPC_CMD_BYTE_PROGRAM);
						flash_sector_erase_out <= (op == `IAFPC_CMD_SECTOR_ERASE);
						count <= (op == `IAFPC_CMD_SECTOR_ERASE) ? ERASE_CYCLES :
							`IAFPC_PROG_CYC;
						osc_enable_out <= 1'b1;
						state <= ST_RUN;
					end else begin
						refused <= 1'b1;
					end
				end
			end
			ST_RUN: begin
				// Whole block runs on ref_clk_in; the wait is counted in ref_clk_in cycles while the oscillator enable is held high
				if (count <= 32'h00000001) begin
					osc_enable_out <= 1'b0;
					state <= ST_DONE;
				end else begin
					count <= count - 32'h00000001;
				end
			end
			ST_DONE: begin
				completion_interrupt_source_out <= flash_command_reg[`IAFPC_CMD_IRQ_BIT];
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	always @* begin
		flash_status_reg = 8'h00;
		flash_status_reg[`IAFPC_ST_BUSY_BIT] = busy;
		flash_status_reg[`IAFPC_ST_REFUSED_BIT] = refused;
	end
endmodule

// >>> iafpc_regs.vh
// Register offsets, fields, codes and timing constants of the flash program control block
`ifndef IAFPC_REGS_VH
`define IAFPC_REGS_VH
// ***************
// Register map
// ***************
`define IAFPC_OFS_STATUS 8'h00
`define IAFPC_OFS_COMMAND 8'h04
`define IAFPC_OFS_ADDR_LOW 8'h08
`define IAFPC_OFS_ADDR_HIGH 8'h0c
`define IAFPC_OFS_DATA 8'h10
`define IAFPC_OFS_CONFIG 8'h14
`define IAFPC_OFS_FETCH 8'h18
`define IAFPC_OFS_LOCK 8'h1c
// ***************
// Fields and reset values
// ***************
`define IAFPC_CFG_ENABLE_BIT 6
`define IAFPC_CMD_IRQ_BIT 7
`define IAFPC_ST_BUSY_BIT 2
`define IAFPC_ST_REFUSED_BIT 0
`define IAFPC_RST_BYTE 8'h00
// ***************
// Command codes and signature locations
// ***************
`define IAFPC_CMD_CHIP_ERASE 7'h01
`define IAFPC_CMD_BLOCK_ERASE 7'h0d
`define IAFPC_CMD_SECTOR_ERASE 7'h0b
`define IAFPC_CMD_BYTE_PROGRAM 7'h0e
`define IAFPC_CMD_BYTE_VERIFY 7'h0c
`define IAFPC_CMD_SIG_READ 7'h02
`define IAFPC_SIG_MAKER_ADDR 16'h0030
`define IAFPC_SIG_DEVICE_ADDR 16'h0031
`define IAFPC_OVERLAY_LIMIT 16'h2000
`define IAFPC_SECTOR_BYTES 128
// ***************
// Timing
// ***************
`define IAFPC_CLK_MHZ 200
`define IAFPC_PROG_US 10
`define IAFPC_ERASE_US 100
`define IAFPC_PROG_CYC (`IAFPC_PROG_US * `IAFPC_CLK_MHZ)
`define IAFPC_ERASE_CYC (`IAFPC_ERASE_US * `IAFPC_CLK_MHZ)
`endif

// >>> iafpc_chk_assertions.sv
// Port checks for the flash program controller
`timescale 1ns/1ps
module iafpc_chk (
	input wire ref_clk_in,
	input wire rst_b_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_ack_out,
	input wire flash_we_out,
	input wire flash_sector_erase_out,
	input wire osc_enable_out,
	input wire completion_interrupt_source_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	chk_ack_idle: assert property (!wb_stb_in |=> !wb_ack_out)
		else $error("ack without request");
	chk_we_pulse: assert property (flash_we_out |=> !flash_we_out)
		else $error("program start too long");
	chk_prog_osc: assert property (flash_we_out |-> osc_enable_out [*8])
		else $error("oscillator off in program");
	chk_erase_osc: assert property (flash_sector_erase_out |-> osc_enable_out)
		else $error("oscillator off in erase");
	chk_irq_pulse: assert property (completion_interrupt_source_out |=> !completion_interrupt_source_out)
		else $error("completion too long");
	chk_irq_osc: assert property (completion_interrupt_source_out |-> !osc_enable_out)
		else $error("oscillator on after done");
endmodule

// >>> iafpc_flash_model.sv
// Behavioural flash array behind the controller
`timescale 1ns/1ps
module iafpc_flash_model (
	input wire clk_in,
	input wire we_in,
	input wire erase_in,
	input wire second_in,
	input wire [15:0] addr_in,
	input wire [7:0] wdata_in,
	output wire [7:0] rdata_out
);
	// Low address byte only per block, enough for the bench
	reg [7:0] mem [0:511];
	wire [8:0] idx = {second_in, addr_in[7:0]};
	integer i;
	initial for (i = 0; i < 512; i = i + 1) mem[i] = 8'hff;
	always @(posedge clk_in) begin
		if (we_in) mem[idx] <= mem[idx] & wdata_in;
		if (erase_in) for (i = 0; i < 128; i = i + 1) mem[{idx[8:7], i[6:0]}] <= 8'hff;
	end
	assign rdata_out = mem[idx];
endmodule

// >>> iafpc_flash_ctrl_tb.sv
// Self-checking bench for the flash program controller
`timescale 1ns/1ps
module iafpc_flash_ctrl_tb;
	reg ref_clk_in = 0, rst_b_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, bz;
	reg external_access_pin_in = 1, fetch_external_in = 0;
	reg [7:0] wb_adr_in = 8'h00;
	reg [3:0] wb_sel_in = 4'h1;
	reg [15:0] fetch_addr_in = 16'h0000;
	reg [31:0] wb_dat_in = 32'h0, q;
	wire [31:0] wb_dat_out;
	wire [15:0] fa;
	wire [7:0] fwd, frd;
	wire wb_ack_out, fwe, fer, fts, irq;
	integer n_mismatch = 0, comparisons = 0, n_we = 0, n_irq = 0, i;
	reg [7:0] ta [0:5] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
	reg [7:0] tw [0:5] = '{8'h34, 8'h12, 8'ha5, 8'h03, 8'h77, 8'h55};
	reg [7:0] te [0:5] = '{8'h34, 8'h12, 8'ha5, 8'h03, 8'h00, 8'h00};
	iafpc_flash_ctrl #(.ERASE_CYCLES(20)) uut (.ref_clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
		.wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
		.external_access_pin_in, .fetch_addr_in, .fetch_external_in, .main_fetch_busy_out(),
		.second_fetch_busy_out(), .flash_we_out(fwe), .flash_sector_erase_out(fer),
		.flash_target_second_out(fts), .flash_addr_out(fa), .flash_wdata_out(fwd),
		.flash_rdata_in(frd), .osc_enable_out(), .completion_interrupt_source_out(irq));
	iafpc_flash_model u_flash (.clk_in(ref_clk_in), .we_in(fwe), .erase_in(fer),
		.second_in(fts), .addr_in(fa), .wdata_in(fwd), .rdata_out(frd));
	always #2.5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		n_we <= n_we + (rst_b_in & fwe);
		n_irq <= n_irq + (rst_b_in & irq);
	end
	task chk(input [31:0] s, input [31:0] e, input string nm);
		comparisons = comparisons + 1;
		if (s !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0s expected %h seen %h", nm, e, s);
		end
	endtask
	task wb(input w, input [7:0] a, input [7:0] d);
		@(posedge ref_clk_in);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, 24'h0, d};
		@(posedge ref_clk_in);
		while (wb_ack_out !== 1'b1) @(posedge ref_clk_in);
		q = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'b00;
	endtask
	task op(input [15:0] f, input e, input [7:0] cf, input [15:0] a, input [7:0] c);
		// Pin goes low whenever code runs from outside; the target may be the fetch block
		// Targets are erased locations only, the model ANDs data in
		{fetch_addr_in, fetch_external_in, external_access_pin_in} <= {f, e, ~e};
		wb(1, 8'h14, cf);
		wb(1, 8'h08, a[7:0]);
		wb(1, 8'h0c, a[15:8]);
		wb(1, 8'h04, c);
		wb(0, 8'h00, 8'h00);
		bz = q[2];
		while (q[2] !== 1'b0) wb(0, 8'h00, 8'h00);
		// Let the completion pulse reach the counters before they are compared
		repeat (2) @(posedge ref_clk_in);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge ref_clk_in);
		rst_b_in <= 1;
		for (i = 0; i < 6; i = i + 1) begin
			wb(1, ta[i], tw[i]);
			wb(0, ta[i], 8'h00);
			chk(q, {24'h0, te[i]}, "register");
		end
		$display("register table done");
		op(16'h0100, 0, 8'h00, 16'h1234, 8'h0e);
		chk(n_we, 0, "disabled");
		op(16'h0100, 0, 8'h40, 16'h1234, 8'h8e);
		chk({bz, n_irq[3:0], n_we[3:0]}, 9'h111, "program");
		chk({fts, fa, fwd}, {1'b0, 16'h1234, 8'ha5}, "target");
		wb(1, 8'h10, 8'h00);
		op(16'h0100, 0, 8'h40, 16'h1234, 8'h0c);
		wb(0, 8'h10, 8'h00);
		chk(q, 32'ha5, "verify");
		op(16'h3000, 0, 8'h40, 16'h3000, 8'h0e);
		chk({q[0], n_we[3:0]}, 5'h11, "same block");
		op(16'h3000, 0, 8'h40, 16'h0100, 8'h0e);
		chk({fts, n_we[3:0]}, 5'h12, "other block");
		op(16'h0000, 1, 8'h40, 16'h0100, 8'h0b);
		chk(fts, 1, "external low");
		op(16'h0000, 1, 8'h41, 16'h0100, 8'h0b);
		chk({fts, n_irq[3:0]}, 5'h01, "external main");
		op(16'h0100, 0, 8'h40, 16'h0030, 8'h02);
		wb(0, 8'h10, 8'h00);
		chk(q, 32'h5a, "signature");
		op(16'h0100, 0, 8'h40, 16'h0031, 8'h02);
		wb(0, 8'h10, 8'h00);
		chk(q, 32'ha5, "device signature");
		wb(1, 8'h1c, 8'h01);
		op(16'h0100, 0, 8'h40, 16'h1240, 8'h0e);
		chk(n_we, 2, "locked");
		$display("command tests done");
		rst_b_in <= 0;
		repeat (2) @(posedge ref_clk_in);
		rst_b_in <= 1;
		wb(0, 8'h14, 8'h00);
		chk(q, 0, "reset config");
		$display("reset test done");
		finish_test;
	end
endmodule
bind iafpc_flash_ctrl iafpc_chk u_chk (.ref_clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
	.wb_ack_out, .flash_we_out, .flash_sector_erase_out, .osc_enable_out,
	.completion_interrupt_source_out);
